// ---- rtl/dlc_pkg.sv ----
// shared constants and types of the delay line controller
package dlc_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned SAMPLE_NS    = 22900;
  localparam int unsigned SAMPLE_TICKS = SAMPLE_NS / CLK_NS;
  localparam int unsigned DISP_HZ      = 43;
  localparam int unsigned DISP_HALF_TICKS = CLK_HZ / (2 * DISP_HZ);
  localparam int unsigned REFRESH_NS   = 15600;
  localparam int unsigned REFRESH_CYC  = REFRESH_NS / CLK_NS;
  localparam int unsigned ACQ_TICKS    = 40;
  localparam int unsigned PLAY_TICKS   = 16;
  localparam int unsigned SETTLE_TICKS = 8;
  localparam int unsigned WORD_W       = 12;
  localparam int unsigned SLICE_W      = 3;
  localparam int unsigned PTR_W        = 14;
  localparam int unsigned ROW_W        = 7;
  localparam int unsigned GRP_W        = 2;
  localparam int unsigned DSTEP_W      = 6;
  localparam int unsigned DELAY_W      = 16;
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STAT      = 8'h04;
  localparam logic [7:0] OFF_DELAY     = 8'h08;
  localparam logic [7:0] OFF_SAMPLE    = 8'h0c;
  localparam int unsigned CTRL_FREEZE  = 0;
  localparam int unsigned CTRL_STRETCH = 1;
  localparam logic [1:0] CTRL_RST      = 2'h0;
  localparam int unsigned STAT_VALID   = 16;
  localparam int unsigned STAT_EDIT    = 17;
  localparam int unsigned STAT_PRESET  = 18;
  localparam int unsigned STAT_FREEZE  = 19;

  typedef enum logic [2:0] {
    ST_ACQ, ST_READ, ST_PLAY, ST_CONV, ST_WRITE, ST_IDLE
  } dlc_state_t;

  typedef struct packed {
    logic       comparator_in;
    logic       range_double_in;
    logic       delay_data_in;
    logic       delay_shift_in;
    logic       edit_mute_n;
    logic       preset_mute_n;
    logic [2:0] dram_din;
    logic [1:0] compand_din;
    logic [1:0] range_code_in;
  } dlc_pins_t;

  typedef struct packed {
    logic [3:0]       ras_n;
    logic [2:0]       cas_n;
    logic             we_n;
    logic [ROW_W-1:0] addr;
    logic [2:0]       dout;
  } dlc_dram_t;

  typedef struct packed {
    logic       compand_strobe;
    logic       we_n;
    logic [1:0] dout;
    logic [1:0] bank_offset_bits;
    logic [1:0] attn_sel;
  } dlc_comp_t;
endpackage

// ---- rtl/dlc_top.sv ----
// delay line controller: pacing, sar conversion, dram store and playback
// How it works
// - conversion starts with msb set, cleared if high
// - kept bit stays, next lower bit tried
// - every decision is stored as the sample word
// - playback reads four 3-bit slices, shows twelve
// - range double doubles all timing except refresh
// - strobe period 22.9us, 45.8us when doubled
// - track while strobe high, hold while low
// - sample rate independent of delay setting
// - bus shows playback word, then trial pattern
// - delay arrives as serial 16-bit shifted word
// - row strobe fall latches row or refresh
// - row strobe selects group, data while column strobes low
// - freeze keeps cycling but blocks memory writes
// - display timebase of about 43 hz
// - group offset 0 to 3 on offset bits
// - range once per sample, slices msb first
// - range code captured as acquisition ends
// - groups used from first upward by delay
// - each cell group read first, then written
// - pointer wraps to first group at limit
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
module dlc_top
  import dlc_pkg::*;
#(
  parameter int unsigned DISP_HALF = DISP_HALF_TICKS
)(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire dlc_pins_t         pins_i,
  output logic                   sample_strobe,
  output logic [WORD_W-1:0]      parallel_converter_bus,
  output dlc_dram_t              dram_o,
  output dlc_comp_t              comp_o,
  output logic                   display_timebase,
  output logic                   playback_mute
);
  localparam int unsigned DISP_W = $clog2(DISP_HALF + 1);
  localparam int unsigned RF_W   = $clog2(REFRESH_CYC + 1);

  dlc_pins_t           meta_q;
  dlc_pins_t           pins_q;
  dlc_state_t          state_q;
  logic [1:0]          ctrl_q;
  logic [1:0]          pre_q;
  logic                tick;
  logic [9:0]          per_q;
  logic [3:0]          idx_q;
  logic [3:0]          tq_q;
  logic [1:0]          sl_q;
  logic [2:0]          mph_q;
  logic [WORD_W-1:0]   sar_q;
  logic [WORD_W-1:0]   last_q;
  logic [2:0][3:0]     buf_q;
  logic [PTR_W-1:0]    ptr_q;
  logic [PTR_W-1:0]    lim;
  logic                valid_q;
  logic [1:0]          rng_q;
  logic [RF_W-1:0]     rf_cnt_q;
  logic                rf_pend_q;
  logic [1:0]          rf_ph_q;
  logic [ROW_W-1:0]    rf_row_q;
  logic                rf_start;
  logic                freeze;
  logic                dbl;
  logic                str;
  logic                sh_prev_q;
  logic [DELAY_W-1:0]  sh_q;
  logic [3:0]          bcnt_q;
  logic [DELAY_W-1:0]  delay_q;
  logic [DISP_W-1:0]   disp_q;
  logic                ap_q;
  logic                ap_wr_q;
  logic [7:0]          ap_addr_q;
  dlc_dram_t           dram_d;
  dlc_comp_t           comp_d;
  logic [GRP_W-1:0]    grp;
  logic                mem_op;

  // pattern of the timing prescaler for the selected range
  function automatic logic [1:0] pre_lim(input logic d, input logic s);
    pre_lim = s ? 2'h2 : (d ? 2'h1 : 2'h0);
  endfunction

  // sar bit positions that close a 3-bit slice
  function automatic logic slice_end(input logic [3:0] i);
    slice_end = (i == 4'h9) || (i == 4'h6) || (i == 4'h3)
             || (i == 4'h0);
  endfunction

  // slice s of a word, msb slice first
  function automatic logic [2:0] slice_of(input logic [WORD_W-1:0] w,
                                         input logic [1:0] s);
    slice_of = w[4'(11 - 3 * s) -: 3];
  endfunction

  // three 4-bit buffers back into one word
  function automatic logic [WORD_W-1:0] assemble(
    input logic [2:0][3:0] b);
    logic [WORD_W-1:0] w;
    w = '0;
    for (int s = 0; s < 4; s++)
    begin
      for (int j = 0; j < 3; j++)
      begin
        w[9 - 3 * s + j] = b[j][3 - s];
      end
    end
    assemble = w;
  endfunction

  // pins cross into clk_sys
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_q <= '0;
      pins_q <= '0;
    end
    else
    begin
      meta_q <= pins_i;
      pins_q <= meta_q;
    end
  end

  assign freeze = ctrl_q[CTRL_FREEZE];
  assign str    = ctrl_q[CTRL_STRETCH];
  assign dbl    = pins_q.range_double_in;

  // sequence tick: every clock, 1 of 2 doubled, 2 of 3 stretched, 1 of 3 doubled and stretched
  always_comb
  begin
    if (dbl)
      tick = (pre_q == 2'h0);
    else if (str)
      tick = (pre_q != 2'h2);
    else
      tick = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || pre_q >= pre_lim(dbl, str))
      pre_q <= 2'h0;
    else
      pre_q <= pre_q + 2'h1;
  end

  // sample period counts ticks only, never the delay setting
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      per_q <= '0;
    else if (tick)
    begin
      if (per_q == 10'(SAMPLE_TICKS - 1))
        per_q <= '0;
      else
        per_q <= per_q + 10'h001;
    end
  end

  // refresh on its own clock count, not slowed by range double
  assign rf_start = rf_pend_q && rf_ph_q == 2'h0
                 && (state_q == ST_ACQ || state_q == ST_IDLE);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rf_cnt_q  <= '0;
      rf_pend_q <= 1'b0;
      rf_ph_q   <= 2'h0;
      rf_row_q  <= '0;
    end
    else
    begin
      if (rf_cnt_q == RF_W'(REFRESH_CYC - 1))
        rf_cnt_q <= '0;
      else
        rf_cnt_q <= rf_cnt_q + RF_W'(1);
      rf_pend_q <= (rf_pend_q && !rf_start)
                || rf_cnt_q == RF_W'(REFRESH_CYC - 1);
      if (rf_start)
        rf_ph_q <= 2'h1;
      else if (rf_ph_q != 2'h0)
        rf_ph_q <= rf_ph_q + 2'h1;
      if (rf_ph_q == 2'h3)
        rf_row_q <= rf_row_q + ROW_W'(1);
    end
  end

  assign lim = {delay_q[DSTEP_W-1:0], {(PTR_W - DSTEP_W){1'b1}}};
  assign grp = ptr_q[PTR_W-1 -: GRP_W];

  // conversion and memory sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_ACQ;
      idx_q   <= 4'hb;
      tq_q    <= 4'h0;
      sl_q    <= 2'h0;
      mph_q   <= 3'h0;
      sar_q   <= '0;
      last_q  <= '0;
      buf_q   <= '0;
      ptr_q   <= '0;
      valid_q <= 1'b0;
      rng_q   <= 2'h0;
    end
    else if (tick)
    begin
      unique case (state_q)
        ST_ACQ:
        begin
          if (per_q >= 10'(ACQ_TICKS - 1) && rf_ph_q == 2'h0
              && !rf_pend_q)
          begin
            if (!freeze)
              rng_q <= pins_q.range_code_in;
            state_q <= ST_READ;
            sl_q    <= 2'h0;
            mph_q   <= 3'h0;
          end
        end
        ST_READ:
        begin
          mph_q <= mph_q + 3'h1;
          if (mph_q == 3'h6)
          begin
            for (int j = 0; j < 3; j++)
            begin
              buf_q[j] <= {buf_q[j][2:0], pins_q.dram_din[j]};
            end
          end
          if (mph_q == 3'h7)
          begin
            sl_q <= sl_q + 2'h1;
            if (sl_q == 2'h3)
            begin
              state_q <= ST_PLAY;
              tq_q    <= 4'h0;
            end
          end
        end
        ST_PLAY:
        begin
          tq_q <= tq_q + 4'h1;
          if (tq_q == 4'(PLAY_TICKS - 1))
          begin
            state_q <= ST_CONV;
            tq_q    <= 4'h0;
            idx_q   <= 4'hb;
            sar_q   <= '0;
          end
        end
        ST_CONV:
        begin
          tq_q <= tq_q + 4'h1;
          if (tq_q == 4'h0)
            sar_q[idx_q] <= 1'b1;
          if (tq_q == 4'(SETTLE_TICKS - 1))
          begin
            tq_q <= 4'h0;
            if (pins_q.comparator_in)
              sar_q[idx_q] <= 1'b0;
            if (slice_end(idx_q))
            begin
              state_q <= ST_WRITE;
              mph_q   <= 3'h0;
            end
            else
              idx_q <= idx_q - 4'h1;
          end
        end
        ST_WRITE:
        begin
          mph_q <= mph_q + 3'h1;
          if (mph_q == 3'h7)
          begin
            sl_q <= sl_q + 2'h1;
            if (sl_q == 2'h3)
            begin
              state_q <= ST_IDLE;
              last_q  <= sar_q;
              if (ptr_q >= lim)
              begin
                ptr_q   <= '0;
                valid_q <= 1'b1;
              end
              else
                ptr_q <= ptr_q + PTR_W'(1);
            end
            else
            begin
              state_q <= ST_CONV;
              idx_q   <= idx_q - 4'h1;
            end
          end
        end
        ST_IDLE:
        begin
          if (per_q == 10'(SAMPLE_TICKS - 1))
            state_q <= ST_ACQ;
        end
      endcase
    end
  end

  assign mem_op = state_q == ST_READ || state_q == ST_WRITE;

  // dram and companding pin values, registered below
  always_comb
  begin
    dram_d        = '0;
    dram_d.ras_n  = 4'hf;
    dram_d.cas_n  = 3'h7;
    dram_d.we_n   = 1'b1;
    comp_d        = comp_o;
    comp_d.compand_strobe = 1'b0;
    comp_d.we_n   = 1'b1;
    comp_d.dout   = rng_q;
    comp_d.bank_offset_bits = grp;
    if (rf_ph_q == 2'h1 || rf_ph_q == 2'h2)
    begin
      dram_d.ras_n = 4'h0;
      dram_d.addr  = rf_row_q;
    end
    else if (mem_op)
    begin
      dram_d.addr = (mph_q == 3'h0) ? ptr_q[11:5]
                                    : {ptr_q[4:0], sl_q};
      if (mph_q != 3'h7)
        dram_d.ras_n[grp] = 1'b0;
      if (mph_q >= 3'h1 && mph_q <= 3'h5
          && !(state_q == ST_WRITE && freeze))
        dram_d.cas_n = 3'h0;
      if (state_q == ST_WRITE)
      begin
        dram_d.we_n = 1'b0;
        dram_d.dout = slice_of(sar_q, sl_q);
        if (sl_q == 2'h0 && mph_q >= 3'h1 && mph_q <= 3'h5
            && !freeze)
          comp_d.we_n = 1'b0;
      end
      else if (sl_q == 2'h0 && mph_q == 3'h6 && tick)
      begin
        comp_d.compand_strobe = 1'b1;
        comp_d.attn_sel = pins_q.compand_din;
      end
    end
  end

  // pin registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dram_o        <= '{ras_n: 4'hf, cas_n: 3'h7, we_n: 1'b1,
                         default: '0};
      comp_o        <= '{we_n: 1'b1, default: '0};
      sample_strobe <= 1'b0;
      playback_mute <= 1'b1;
    end
    else
    begin
      dram_o        <= dram_d;
      comp_o        <= comp_d;
      sample_strobe <= state_q == ST_ACQ && !freeze
                    && per_q < 10'(ACQ_TICKS);
      playback_mute <= !valid_q || !pins_q.edit_mute_n
                    || !pins_q.preset_mute_n;
    end
  end

  // converter bus: live trial or buffered playback word
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      parallel_converter_bus <= '0;
    else if (state_q == ST_CONV || state_q == ST_WRITE)
      parallel_converter_bus <= sar_q;
    else if (state_q == ST_PLAY)
      parallel_converter_bus <= assemble(buf_q);
  end

  // serial delay word, msb first on shift rise
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sh_prev_q <= 1'b0;
      sh_q      <= '0;
      bcnt_q    <= 4'h0;
      delay_q   <= '0;
    end
    else
    begin
      sh_prev_q <= pins_q.delay_shift_in;
      if (!pins_q.edit_mute_n || !pins_q.preset_mute_n)
        bcnt_q <= 4'h0;
      else if (pins_q.delay_shift_in && !sh_prev_q)
      begin
        sh_q   <= {sh_q[DELAY_W-2:0], pins_q.delay_data_in};
        bcnt_q <= bcnt_q + 4'h1;
        if (bcnt_q == 4'hf)
          delay_q <= {sh_q[DELAY_W-2:0], pins_q.delay_data_in};
      end
    end
  end

  // display timebase, slowed with the sequence
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      disp_q           <= '0;
      display_timebase <= 1'b0;
    end
    else if (tick)
    begin
      if (disp_q == DISP_W'(DISP_HALF - 1))
      begin
        disp_q           <= '0;
        display_timebase <= !display_timebase;
      end
      else
        disp_q <= disp_q + DISP_W'(1);
    end
  end

  // ahb-lite slave, one wait state per transfer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ap_q      <= 1'b0;
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
      ctrl_q    <= CTRL_RST;
    end
    else if (ap_q)
    begin
      ap_q      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= '0;
      if (ap_wr_q && ap_addr_q == OFF_CTRL)
        ctrl_q <= hwdata[1:0];
      else if (!ap_wr_q)
      begin
        unique case (ap_addr_q)
          OFF_CTRL:   hrdata <= {30'h0, ctrl_q};
          OFF_STAT:   hrdata <= {12'h0, freeze,
                                 pins_q.preset_mute_n,
                                 pins_q.edit_mute_n, valid_q,
                                 2'h0, ptr_q};
          OFF_DELAY:  hrdata <= {16'h0, delay_q};
          OFF_SAMPLE: hrdata <= {20'h0, last_q};
          default:    hrdata <= '0;
        endcase
      end
    end
    else if (hsel && htrans[1] && hready)
    begin
      ap_q      <= 1'b1;
      ap_wr_q   <= hwrite;
      ap_addr_q <= {haddr[7:2], 2'h0};
      hreadyout <= 1'b0;
    end
  end
endmodule

// ---- sim/dlc_monitor.sv ----
// port assertions for the delay line controller
module dlc_monitor
  import dlc_pkg::*;
#(
  parameter int unsigned DISP_HALF = DISP_HALF_TICKS
)(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire dlc_pins_t  pins_i,
  input wire logic       sample_strobe,
  input wire dlc_dram_t  dram_o,
  input wire dlc_comp_t  comp_o,
  input wire logic       display_timebase,
  input wire logic       playback_mute
);
  int unsigned per_q;
  int unsigned half_q;
  logic [1:0]  nper_q;
  logic [1:0]  nhalf_q;
  logic [1:0]  nwr_q;

  default clocking mcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // periods measured once the synced range pin or a control write settled
  always_ff @(posedge clk_sys)
  begin
    if (rst || $past(pins_i.range_double_in, 2)
        != $past(pins_i.range_double_in, 3)
        || $past(hsel && htrans[1] && hready && hwrite, 2))
    begin
      per_q <= 0;
      half_q <= 0;
      nper_q <= 2'h0;
      nhalf_q <= 2'h0;
    end
    else
    begin
      per_q <= $rose(sample_strobe) ? 1 : per_q + 1;
      half_q <= $changed(display_timebase) ? 1 : half_q + 1;
      if ($rose(sample_strobe) && nper_q != 2'h2)
        nper_q <= nper_q + 2'h1;
      if ($changed(display_timebase) && nhalf_q != 2'h2)
        nhalf_q <= nhalf_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || $rose(sample_strobe))
      nwr_q <= 2'h0;
    else if ($fell(comp_o.we_n) && nwr_q != 2'h3)
      nwr_q <= nwr_q + 2'h1;
  end

  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_ahb_wait:
    assert property (hsel && htrans[1] && hready |=> s_wait)
    else $error("bus wait state wrong");
  a_ahb_okay:
    assert property (!hresp)
    else $error("bus response not okay");
  a_reset_quiet:
    assert property (disable iff (1'b0) rst |=> dram_o.ras_n == 4'hf
      && dram_o.cas_n == 3'h7 && playback_mute && !sample_strobe)
    else $error("outputs not idle after reset");
  a_row_first:
    assert property ($fell(dram_o.cas_n[0]) |->
      $past(dram_o.ras_n) != 4'hf)
    else $error("column strobe without row strobe");
  a_cas_hold:
    assert property ($fell(dram_o.cas_n[0]) |-> !dram_o.cas_n[0] [*5])
    else $error("column strobe too short");
  a_quiet_acq:
    assert property (sample_strobe |-> dram_o.cas_n == 3'h7
      && dram_o.we_n && comp_o.we_n)
    else $error("memory access while tracking");
  a_range_once:
    assert property (nwr_q <= 2'h1)
    else $error("range code written twice per sample");
  a_strobe_pulse:
    assert property (comp_o.compand_strobe |=> !comp_o.compand_strobe)
    else $error("compand strobe not a pulse");
  a_sample_period:
    assert property ($rose(sample_strobe) && nper_q == 2'h2 |->
      per_q inside {SAMPLE_TICKS, 2 * SAMPLE_TICKS, 3 * SAMPLE_TICKS,
      (3 * SAMPLE_TICKS) / 2})
    else $error("sample period wrong");
  a_disp_half:
    assert property ($changed(display_timebase) && nhalf_q == 2'h2 |->
      half_q inside {DISP_HALF, 2 * DISP_HALF, 3 * DISP_HALF,
      (3 * DISP_HALF) / 2})
    else $error("display timebase half period wrong");
endmodule

bind dlc_top dlc_monitor #(.DISP_HALF(DISP_HALF)) u_mon (
  .clk_sys, .rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .pins_i, .sample_strobe, .dram_o, .comp_o, .display_timebase,
  .playback_mute
);

// ---- sim/dlc_partner.sv ----
// far side: hold gate, comparator and the three sample rams
module dlc_partner
  import dlc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sample_strobe,
  input  wire logic [WORD_W-1:0] parallel_converter_bus,
  input  wire dlc_dram_t         dram_o,
  input  wire logic [WORD_W-1:0] analog_in,
  output logic                   comparator_in,
  output logic [2:0]             dram_din,
  output logic [WORD_W-1:0]      wr_word
);
  logic [WORD_W-1:0] held;
  logic [ROW_W-1:0]  row_q;
  logic [ROW_W-1:0]  col_q;
  logic [3:0]        ras_p;
  logic [2:0]        cas_p;
  logic [2:0]        mem [0:16383];

  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 3'(i); // fresh cells hold their low address bits
    dram_din = 3'h0;
    wr_word = '0;
    ras_p = 4'hf;
    cas_p = 3'h7;
  end

  always_latch
  begin
    if (sample_strobe)
      held <= analog_in;
  end

  assign comparator_in = parallel_converter_bus > held;

  // outputs settle by the falling edge, so strobes are judged there
  always @(negedge clk_sys)
  begin
    if (&ras_p && !(&dram_o.ras_n))
      row_q <= dram_o.addr;
    if (&cas_p && !(&dram_o.cas_n))
    begin
      col_q <= dram_o.addr;
      if (!dram_o.we_n)
      begin
        mem[{row_q, dram_o.addr}] <= dram_o.dout;
        wr_word <= {wr_word[8:0], dram_o.dout};
      end
    end
    // released data line toggles so a stale value never looks valid
    if (!(&cas_p) && !(&dram_o.cas_n))
      dram_din <= mem[{row_q, col_q}];
    else
      dram_din <= ~dram_din;
    ras_p <= dram_o.ras_n;
    cas_p <= dram_o.cas_n;
  end
endmodule

// ---- sim/tb_delay_line_controller.sv ----
// self-checking bench for the delay line controller
module tb_delay_line_controller
  import dlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DISP_T = 20;
  logic              clk_sys;
  logic              rst;
  logic              hsel;
  logic [31:0]       haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [31:0]       hwdata;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  dlc_pins_t         pins;
  logic              cmp;
  logic              range_dbl;
  logic              ser_data;
  logic              ser_clk;
  logic              edit_n;
  logic              preset_n;
  logic [2:0]        din;
  logic [WORD_W-1:0] analog;
  logic [WORD_W-1:0] wr_word;
  logic              sample_strobe;
  logic [WORD_W-1:0] parallel_converter_bus;
  dlc_dram_t         dram_o;
  dlc_comp_t         comp_o;
  logic              display_timebase;
  logic              playback_mute;
  int                bad_count;
  int                checked;
  int                cyc;

  assign pins = '{cmp, range_dbl, ser_data, ser_clk, edit_n, preset_n,
                  din, 2'h1, 2'h2};

  dlc_top #(.DISP_HALF(DISP_T)) DUT (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pins_i(pins),
    .sample_strobe, .parallel_converter_bus, .dram_o, .comp_o,
    .display_timebase, .playback_mute
  );

  dlc_partner u_far (
    .clk_sys, .sample_strobe, .parallel_converter_bus, .dram_o,
    .analog_in(analog), .comparator_in(cmp), .dram_din(din), .wr_word
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys)
    cyc++;

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      ser_data <= w[i];
      repeat (4) @(posedge clk_sys);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic wait_strobe(input logic lvl);
    do @(posedge clk_sys); while (sample_strobe === lvl);
    do @(posedge clk_sys); while (sample_strobe !== lvl);
  endtask

  task automatic wait_disp;
    logic v;
    v = display_timebase;
    do @(posedge clk_sys); while (display_timebase === v);
  endtask

  task automatic t_reset;
    logic [31:0] rd;
    check(playback_mute, 1'b1);
    ahb(1'b0, OFF_STAT, 0, rd);
    check(rd & 32'h3fff, 0);
    ahb(1'b0, 32'h10, 0, rd);
    check(rd, 0);
  endtask

  task automatic t_serial;
    logic [31:0] rd;
    send_word(16'h003f);
    ahb(1'b0, OFF_DELAY, 0, rd);
    check(rd & 32'hffff, 16'h003f);
    edit_n <= 1'b0;
    preset_n <= 1'b0;
    send_word(16'h0011);
    ahb(1'b0, OFF_DELAY, 0, rd);
    check(rd & 32'hffff, 16'h003f);
    ahb(1'b0, OFF_STAT, 0, rd);
    check(rd[18:17], 2'h0);
    edit_n <= 1'b1;
    preset_n <= 1'b1;
  endtask

  task automatic t_period;
    int n;
    int k;
    logic r;
    logic [31:0] rd;
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 2);
      k = (i == 3) ? 3 : 2 + 2 * r;
      send_word(i == 0 ? 16'h003f : 16'h0000);
      range_dbl <= r;
      if (i == 3)
        ahb(1'b1, OFF_CTRL, 32'h2, rd);
      wait_strobe(1'b1);
      wait_strobe(1'b1);
      n = cyc;
      wait_strobe(1'b1);
      check(cyc - n, (SAMPLE_TICKS * k) / 2);
      wait_disp;
      n = cyc;
      wait_disp;
      check(cyc - n, (DISP_T * k) / 2);
    end
    range_dbl <= 1'b0;
    ahb(1'b1, OFF_CTRL, 0, rd);
  endtask

  task automatic t_convert;
    logic [31:0] rd;
    logic [11:0] w;
    analog <= 12'he38;
    wait_strobe(1'b1);
    ahb(1'b0, OFF_STAT, 0, rd);
    w = rd[0] ? 12'h977 : 12'h053;
    wait_strobe(1'b0);
    // fresh cells play back their preset content
    repeat (40) @(posedge clk_sys);
    check(parallel_converter_bus, w);
    analog <= 12'h1c7;
    for (int i = 0; i < 400 && parallel_converter_bus !== 12'h800; i++)
      @(posedge clk_sys);
    check(parallel_converter_bus, 12'h800);
    for (int i = 0; i < 20 && parallel_converter_bus === 12'h800; i++)
      @(posedge clk_sys);
    check(parallel_converter_bus, 12'hc00);
    wait_strobe(1'b1);
    ahb(1'b0, OFF_SAMPLE, 0, rd);
    check(rd & 32'hfff, 12'he38);
    check(wr_word, 12'he38);
    wait_strobe(1'b0);
    wait_strobe(1'b1);
    ahb(1'b0, OFF_SAMPLE, 0, rd);
    check(rd & 32'hfff, 12'h1c7);
    check(wr_word, 12'h1c7);
  endtask

  task automatic t_freeze;
    logic [31:0] rd;
    logic [11:0] w;
    logic        hi;
    logic        cv;
    ahb(1'b1, OFF_CTRL, 32'h1, rd);
    ahb(1'b0, OFF_CTRL, 0, rd);
    check(rd, 32'h1);
    ahb(1'b0, OFF_STAT, 0, rd);
    check(rd[STAT_FREEZE], 1'b1);
    w = wr_word;
    hi = 1'b0;
    cv = 1'b0;
    analog <= 12'h5a5;
    repeat (600)
    begin
      @(posedge clk_sys);
      hi |= sample_strobe;
      cv |= (parallel_converter_bus === 12'h800);
    end
    check(wr_word, w);
    check(hi, 1'b0);
    check(cv, 1'b1);
    ahb(1'b1, OFF_CTRL, 0, rd);
  endtask

  task automatic finish_test;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #2_000_000;
    bad_count++;
    finish_test;
  end

  initial
  begin
    rst <= 1'b1;
    hsel <= 1'b1;
    haddr <= '0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    hwdata <= '0;
    range_dbl <= 1'b0;
    ser_data <= 1'b0;
    ser_clk <= 1'b0;
    edit_n <= 1'b1;
    preset_n <= 1'b1;
    analog <= '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_serial;
    t_period;
    t_convert;
    t_freeze;
    finish_test;
  end
endmodule
